/* rtl/adcf_pkg.sv */
// Package: register map, field layout and timing constants of the converter
package adcf_pkg;
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_POSSEL = 8'h04;
   localparam logic [7:0] OFF_NEGSEL = 8'h08;
   localparam logic [7:0] OFF_COMMAND = 8'h0C;
   localparam logic [7:0] OFF_INIT_DELAY = 8'h10;
   localparam logic [7:0] OFF_SAMPLE_LENGTH = 8'h14;
   localparam logic [7:0] OFF_RESULT = 8'h18;
   localparam logic [7:0] OFF_STATUS = 8'h1C;
   localparam int CTRL_DIFF_BIT = 0;
   localparam int CTRL_LEFT_BIT = 1;
   localparam int CTRL_ACC_LSB = 2;
   localparam int CMD_START_BIT = 0;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_TEMPOK_BIT = 1;
   localparam logic [4:0] RST_CTRL = 5'h00;
   localparam logic [7:0] RST_SEL = 8'h00;
   localparam logic [15:0] RST_DLY = 16'h0000;
   localparam logic [15:0] RST_RESULT = 16'h0000;
   // Sampling always lasts this many cycles beyond sample_length
   localparam logic [16:0] SAMP_BASE = 17'h00002;
   localparam logic [16:0] CONV_CYCLES = 17'h0000D;
   localparam logic [2:0] ACC_TRUNC_FROM = 3'h4;
   localparam logic [4:0] CODE_BITS = 5'h0C;
   // Arbitrary code for the on-chip temperature sensor input
   localparam logic [7:0] TEMP_SENSOR_SEL = 8'h42;
   localparam int unsigned TEMP_INIT_US = 25;
   localparam int unsigned TEMP_SAMP_US = 28;
   localparam int unsigned TEMP_INIT_CYC = (TEMP_INIT_US * CLK_HZ + 999_999)
      / 1_000_000;
   localparam int unsigned TEMP_SAMP_CYC = (TEMP_SAMP_US * CLK_HZ + 999_999)
      / 1_000_000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [2:0] accumulateCount;
      logic leftAdjust;
      logic diffMode;
   } adcf_ctrl_s;

   typedef struct packed {
      logic [7:0] pos;
      logic [7:0] neg;
   } adcf_sel_s;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_INIT = 2'b01,
      ST_SAMPLE = 2'b10,
      ST_CONV = 2'b11
   } adcf_state_e;
endpackage : adcf_pkg

/* rtl/adcf_result_chsel.sv */
// Converter control: channel selection buffering, sequencing, result format
// Function
// - Single-ended uses positive input only; differential uses both.
// - Written channel selections go through a holding register first.
// - While idle the active selection follows the holding register.
// - Once a conversion starts, the active selection stays frozen.
// - Copying resumes in the final converter cycle before completion.
// - Conversion begins on the first clock edge after start is written.
// - Differential right-adjusted single result is sign extended to 16 bits.
// - Over 16 accumulated samples, low bits are dropped to fit 16 bits.
// - Results right-adjusted by default; left_adjust moves MSBs to top for up to 16 samples.
// - Start command sets on trigger and clears when conversion completes.
`timescale 1ns/10ps
`default_nettype none
module adcf_result_chsel
   import adcf_pkg::*;
#(
   parameter int DLY_W = 16
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [11:0] rawCode,
   output logic [7:0] activePosSel,
   output logic [7:0] activeNegSel,
   output logic negInputEnable,
   output logic tempSensorSel,
   output logic sampling
);
   adcf_ctrl_s ctrl_reg;
   adcf_sel_s hold_reg, active_reg;
   adcf_state_e state_reg;
   logic [DLY_W-1:0] init_delay_reg, sample_length_reg;
   logic [15:0] result_reg, formatted;
   logic [16:0] cnt_reg;
   logic [6:0] sampIdx_reg;
   logic signed [19:0] acc_reg, codeExt, sumNext;
   logic [7:0] awAddr_reg;
   logic [31:0] wData_reg, rData_reg;
   logic [3:0] wStrb_reg;
   logic [1:0] bResp_reg, rResp_reg;
   logic awFull_reg, wFull_reg, bValid_reg, rValid_reg, startCmd_reg;
   logic doWrite, lastSample, sampleDone, convDone, lastCycle, tempTimingOk;

   // Bus: address and data are taken independently, answered once both held
   assign s_axi_awready = !awFull_reg && !bValid_reg;
   assign s_axi_wready = !wFull_reg && !bValid_reg;
   assign s_axi_bvalid = bValid_reg;
   assign s_axi_bresp = bResp_reg;
   assign s_axi_arready = !rValid_reg;
   assign s_axi_rvalid = rValid_reg;
   assign s_axi_rdata = rData_reg;
   assign s_axi_rresp = rResp_reg;
   assign doWrite = awFull_reg && wFull_reg && !bValid_reg;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         awFull_reg <= 1'b0;
         awAddr_reg <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awFull_reg <= 1'b1;
         awAddr_reg <= s_axi_awaddr;
      end else if (doWrite) begin
         awFull_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wFull_reg <= 1'b0;
         wData_reg <= 32'h00000000;
         wStrb_reg <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wFull_reg <= 1'b1;
         wData_reg <= s_axi_wdata;
         wStrb_reg <= s_axi_wstrb;
      end else if (doWrite) begin
         wFull_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         bValid_reg <= 1'b0;
         bResp_reg <= RESP_OKAY;
      end else if (doWrite) begin
         bValid_reg <= 1'b1;
         bResp_reg <= (awAddr_reg[7:5] == 3'h0 && awAddr_reg[1:0] == 2'h0)
            ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bValid_reg <= 1'b0;
      end
   end

   // Configuration registers; a byte lane only lands where its strobe is set
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl_reg <= RST_CTRL;
         init_delay_reg <= RST_DLY;
         sample_length_reg <= RST_DLY;
      end else if (doWrite) begin
         if (awAddr_reg == OFF_CTRL && wStrb_reg[0])
            ctrl_reg <= wData_reg[4:0];
         if (awAddr_reg == OFF_INIT_DELAY) begin
            if (wStrb_reg[0]) init_delay_reg[7:0] <= wData_reg[7:0];
            if (wStrb_reg[1]) init_delay_reg[15:8] <= wData_reg[15:8];
         end
         if (awAddr_reg == OFF_SAMPLE_LENGTH) begin
            if (wStrb_reg[0]) sample_length_reg[7:0] <= wData_reg[7:0];
            if (wStrb_reg[1]) sample_length_reg[15:8] <= wData_reg[15:8];
         end
      end
   end

   // Writes with byte lane 0 strobed always land here, whatever the converter is doing
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hold_reg <= {RST_SEL, RST_SEL};
      end else if (doWrite && wStrb_reg[0]) begin
         if (awAddr_reg == OFF_POSSEL) hold_reg.pos <= wData_reg[7:0];
         if (awAddr_reg == OFF_NEGSEL) hold_reg.neg <= wData_reg[7:0];
      end
   end

   // Copy only when idle or in the final cycle, so sampling sees a stable mux
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         active_reg <= {RST_SEL, RST_SEL};
      end else if (state_reg == ST_IDLE || lastCycle) begin
         active_reg <= hold_reg;
      end
   end

   // Start sets on a written one; a new set beats completion's clear
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         startCmd_reg <= 1'b0;
      end else if (doWrite && awAddr_reg == OFF_COMMAND && wStrb_reg[0]
            && wData_reg[CMD_START_BIT]) begin
         startCmd_reg <= 1'b1;
      end else if (convDone) begin
         startCmd_reg <= 1'b0;
      end
   end

   assign lastSample = sampIdx_reg == 7'((8'h01 << ctrl_reg.accumulateCount)
      - 8'h01);
   assign sampleDone = state_reg == ST_CONV && cnt_reg == 17'h00000;
   assign convDone = sampleDone && lastSample;
   assign lastCycle = convDone;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 17'h00000;
         sampIdx_reg <= 7'h00;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               sampIdx_reg <= 7'h00;
               if (startCmd_reg) begin
                  if (init_delay_reg != RST_DLY) begin
                     state_reg <= ST_INIT;
                     cnt_reg <= 17'(init_delay_reg) - 17'h00001;
                  end else begin
                     state_reg <= ST_SAMPLE;
                     cnt_reg <= SAMP_BASE + 17'(sample_length_reg) - 17'h00001;
                  end
               end
            end
            ST_INIT: begin
               if (cnt_reg == 17'h00000) begin
                  state_reg <= ST_SAMPLE;
                  cnt_reg <= SAMP_BASE + 17'(sample_length_reg) - 17'h00001;
               end else begin
                  cnt_reg <= cnt_reg - 17'h00001;
               end
            end
            ST_SAMPLE: begin
               if (cnt_reg == 17'h00000) begin
                  state_reg <= ST_CONV;
                  cnt_reg <= CONV_CYCLES - 17'h00001;
               end else begin
                  cnt_reg <= cnt_reg - 17'h00001;
               end
            end
            ST_CONV: begin
               if (convDone) begin
                  state_reg <= ST_IDLE;
               end else if (sampleDone) begin
                  state_reg <= ST_SAMPLE;
                  sampIdx_reg <= sampIdx_reg + 7'h01;
                  cnt_reg <= SAMP_BASE + 17'(sample_length_reg) - 17'h00001;
               end else begin
                  cnt_reg <= cnt_reg - 17'h00001;
               end
            end
         endcase
      end
   end

   // Differential codes are two's complement, single-ended ones unsigned
   assign codeExt = ctrl_reg.diffMode ? 20'(signed'(rawCode))
      : 20'({8'h00, rawCode});
   assign sumNext = (sampIdx_reg == 7'h00) ? codeExt : acc_reg + codeExt;

   // The sum is already sign or zero extended, so right adjust is a slice
   always_comb begin
      formatted = sumNext[15:0];
      if (ctrl_reg.accumulateCount > ACC_TRUNC_FROM) begin
         formatted = 16'(sumNext >>> (ctrl_reg.accumulateCount
            - ACC_TRUNC_FROM));
      end else if (ctrl_reg.leftAdjust) begin
         formatted = 16'(sumNext <<< (5'h10 - CODE_BITS
            - 5'(ctrl_reg.accumulateCount)));
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         acc_reg <= 20'sh00000;
         result_reg <= RST_RESULT;
      end else if (sampleDone) begin
         acc_reg <= sumNext;
         if (lastSample) result_reg <= formatted;
      end
   end

   // Shows software whether the sensor timing it set is long enough
   assign tempTimingOk = active_reg.pos == TEMP_SENSOR_SEL
      && 32'(init_delay_reg) >= TEMP_INIT_CYC
      && 32'(sample_length_reg) >= TEMP_SAMP_CYC;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rValid_reg <= 1'b0;
         rData_reg <= 32'h00000000;
         rResp_reg <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rValid_reg <= 1'b1;
         rResp_reg <= RESP_OKAY;
         rData_reg <= 32'h00000000;
         unique case (s_axi_araddr)
            OFF_CTRL: rData_reg <= 32'(ctrl_reg);
            OFF_POSSEL: rData_reg <= 32'(hold_reg.pos);
            OFF_NEGSEL: rData_reg <= 32'(hold_reg.neg);
            OFF_COMMAND: rData_reg <= 32'(startCmd_reg);
            OFF_INIT_DELAY: rData_reg <= 32'(init_delay_reg);
            OFF_SAMPLE_LENGTH: rData_reg <= 32'(sample_length_reg);
            OFF_RESULT: rData_reg <= 32'(result_reg);
            OFF_STATUS: rData_reg <= 32'({tempTimingOk,
               state_reg != ST_IDLE});
            default: rResp_reg <= RESP_SLVERR;
         endcase
      end else if (s_axi_rready) begin
         rValid_reg <= 1'b0;
      end
   end

   assign activePosSel = active_reg.pos;
   assign activeNegSel = active_reg.neg;
   assign negInputEnable = ctrl_reg.diffMode;
   assign tempSensorSel = active_reg.pos == TEMP_SENSOR_SEL;
   assign sampling = state_reg == ST_SAMPLE;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   chk_sel_locked: assert property (
      state_reg != ST_IDLE && !$past(lastCycle) && $past(state_reg) != ST_IDLE
      |-> $stable(active_reg))
      else $error("active selection changed during conversion");
   chk_sel_follow: assert property (
      state_reg == ST_IDLE |=> active_reg == $past(hold_reg))
      else $error("idle selection did not follow holding");
   chk_sel_resume: assert property (
      lastCycle |=> active_reg == $past(hold_reg) && state_reg == ST_IDLE)
      else $error("selection not copied in final cycle");
   chk_start_edge: assert property (
      state_reg == ST_IDLE && startCmd_reg |=> state_reg != ST_IDLE)
      else $error("conversion did not begin after start");
   chk_start_clear: assert property (
      convDone && !doWrite |=> !startCmd_reg ##1 state_reg == ST_IDLE)
      else $error("start command not cleared at completion");
   chk_diff_sign: assert property (
      convDone && ctrl_reg.diffMode && !ctrl_reg.leftAdjust
      && ctrl_reg.accumulateCount == 3'h0
      |=> result_reg == {{4{$past(rawCode[11])}}, $past(rawCode)})
      else $error("differential result not sign extended");
   chk_se_right: assert property (
      convDone && !ctrl_reg.diffMode && !ctrl_reg.leftAdjust
      && ctrl_reg.accumulateCount == 3'h0
      |=> result_reg == {4'h0, $past(rawCode)})
      else $error("single-ended result not right aligned");
   chk_left_adj: assert property (
      convDone && ctrl_reg.leftAdjust && ctrl_reg.accumulateCount == 3'h0
      |=> result_reg == {$past(rawCode), 4'h0})
      else $error("left adjusted result misplaced");
   chk_hold_keep: assert property (
      state_reg != ST_IDLE && !doWrite |=> $stable(hold_reg))
      else $error("held selection lost during conversion");
   chk_hold_land: assert property (
      doWrite && wStrb_reg[0] && awAddr_reg == OFF_POSSEL
      |=> hold_reg.pos == $past(wData_reg[7:0]))
      else $error("written positive selection not held");
   chk_neg_use: assert property (
      negInputEnable == ctrl_reg.diffMode)
      else $error("negative input use does not match mode");

   cov_single: cover property (convDone && ctrl_reg.accumulateCount == 3'h0);
   cov_accum: cover property (convDone && ctrl_reg.accumulateCount == 3'h6);
   cov_locked_wr: cover property (doWrite && awAddr_reg == OFF_POSSEL
      && state_reg == ST_SAMPLE);
   cov_temp: cover property (convDone && tempSensorSel);
endmodule : adcf_result_chsel
`default_nettype wire

/* tb/adcf_analog_model.sv */
// Analog side model: input channels and the on-chip temperature sensor
`timescale 1ns/10ps
`default_nettype none
module adcf_analog_model
   import adcf_pkg::*;
#(
   parameter logic [11:0] TEMP_CODE = 12'h5A3
) (
   input wire logic [7:0] activePosSel,
   input wire logic [7:0] activeNegSel,
   input wire logic negInputEnable,
   input wire logic tempSensorSel,
   output logic [11:0] rawCode
);
   logic [11:0] posLevel;
   logic [11:0] negLevel;
   // Each pin carries a level derived from its channel number
   assign posLevel = tempSensorSel ? TEMP_CODE
      : {activePosSel[3:0], activePosSel};
   assign negLevel = {activeNegSel[3:0], activeNegSel};
   // Halved levels keep a difference inside the signed code range
   assign rawCode = negInputEnable ? (posLevel >> 1) - (negLevel >> 1)
      : posLevel;
endmodule : adcf_analog_model
`default_nettype wire

/* tb/adcf_result_chsel_test.sv */
// Self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
module adcf_result_chsel_test;
   import adcf_pkg::*;
   localparam logic [11:0] TEMP_CODE = 12'h5A3;
   logic clk_sys, rst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, negEn, tempSel, sampling;
   logic [7:0] awaddr, araddr, actPos, actNeg, curPos, curNeg, nPos, nNeg;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [11:0] rawCode;
   int miscompares, samples_checked, n, k;

   adcf_result_chsel DUT (.clk_sys(clk_sys), .rst(rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rawCode(rawCode),
      .activePosSel(actPos), .activeNegSel(actNeg), .negInputEnable(negEn),
      .tempSensorSel(tempSel), .sampling(sampling));
   adcf_analog_model #(.TEMP_CODE(TEMP_CODE)) analog (.activePosSel(actPos),
      .activeNegSel(actNeg), .negInputEnable(negEn), .tempSensorSel(tempSel),
      .rawCode(rawCode));

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task conclude;
      $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude

   task timeout;
      miscompares++;
      $display("Error at %0t: wait ran out", $time);
      conclude();
   endtask : timeout

   task check(input logic [31:0] got, input logic [31:0] want, string what);
      samples_checked++;
      if (got !== want) begin
         miscompares++;
         $display("Error at %0t: %s got %h want %h", $time, what, got, want);
      end
   endtask : check

   function automatic logic [1:0] respFor(input logic [7:0] a);
      return (a <= OFF_STATUS && a[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
   endfunction : respFor

   function automatic logic [11:0] expCode(input logic [7:0] p8,
      input logic [7:0] n8, input logic diff);
      logic [11:0] p;
      logic [11:0] q;
      p = (p8 == TEMP_SENSOR_SEL) ? TEMP_CODE : {p8[3:0], p8};
      q = {n8[3:0], n8};
      return diff ? (p >> 1) - (q >> 1) : p;
   endfunction : expCode

   function automatic logic [15:0] expRes(input logic [11:0] c,
      input logic diff, input logic left, input logic [2:0] acc);
      logic signed [19:0] s;
      s = diff ? {{8{c[11]}}, c} : {8'h00, c};
      s = s <<< acc;
      // Wide sums lose low bits and ignore the adjust bit
      if (acc > ACC_TRUNC_FROM)
         s = s >>> (acc - ACC_TRUNC_FROM);
      else if (left)
         s = s <<< (ACC_TRUNC_FROM - acc);
      return s[15:0];
   endfunction : expRes

   task wr(input logic [7:0] a, input logic [31:0] v);
      int i;
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk_sys);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      if (i == 50) timeout();
      bready <= 1'b0;
      check({30'h0, bresp}, {30'h0, respFor(a)}, "write response");
   endtask : wr

   task rd(input logic [7:0] a, output logic [31:0] v);
      int i;
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk_sys);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      if (i == 50) timeout();
      v = rdata;
      rready <= 1'b0;
      check({30'h0, rresp}, {30'h0, respFor(a)}, "read response");
   endtask : rd

   task convert(input logic diff, input logic left, input logic [2:0] acc,
      input logic [15:0] slen, input logic [15:0] dly);
      logic [15:0] want;
      int i;
      want = expRes(expCode(curPos, curNeg, diff), diff, left, acc);
      wr(OFF_CTRL, {27'h0, acc, left, diff});
      check(32'(negEn), 32'(diff), "neg use");
      wr(OFF_SAMPLE_LENGTH, {16'h0, slen});
      wr(OFF_INIT_DELAY, {16'h0, dly});
      wr(OFF_COMMAND, 32'h1);
      for (i = 0; i < 2 && sampling !== 1'b1; i++) @(posedge clk_sys);
      if (dly == 16'h0) check({31'h0, sampling}, 32'h1, "start");
      wr(OFF_POSSEL, {24'h0, nPos});
      wr(OFF_NEGSEL, {24'h0, nNeg});
      check(32'({actPos, actNeg}), 32'({curPos, curNeg}), "lock");
      rd(OFF_POSSEL, d);
      check(d, {24'h0, nPos}, "held");
      rd(OFF_COMMAND, d);
      check(d, 32'h1, "start set");
      for (i = 0; i < 4000; i++) begin
         rd(OFF_STATUS, d);
         if (d[STAT_BUSY_BIT] === 1'b0) break;
      end
      if (i == 4000) timeout();
      rd(OFF_RESULT, d);
      check(d, {16'h0, want}, "result");
      rd(OFF_COMMAND, d);
      check(d, 32'h0, "start clear");
      check({16'h0, actPos, actNeg}, {16'h0, nPos, nNeg}, "apply");
      curPos = nPos;
      curNeg = nNeg;
   endtask : convert

   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hF;
      rst = 1'b1;
      miscompares = 0;
      samples_checked = 0;
      void'($urandom(32'hBED8));
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      // Last address is unmapped: error response with zero data
      for (k = 0; k < 9; k++) begin
         rd(8'(k * 4), d);
         check(d, 32'h0, "reset value");
      end
      wr(8'h24, 32'h1);
      wr(OFF_RESULT, 32'hFFFF);
      rd(OFF_RESULT, d);
      check(d, 32'h0, "result read-only");
      // Only byte lane 0 is enabled, so the upper delay byte keeps its value
      wstrb <= 4'h1;
      wr(OFF_INIT_DELAY, 32'h0000ABCD);
      wstrb <= 4'hF;
      rd(OFF_INIT_DELAY, d);
      check(d, 32'h000000CD, "byte lane");
      $display("Test registers done");
      curPos = 8'h00;
      curNeg = 8'h00;
      for (n = 0; n < 12; n++) begin
         // Step 7 primes a negative difference for the step after it
         nPos = (n == 7) ? 8'h01 : 8'($urandom);
         nNeg = (n == 7) ? 8'hFE : 8'($urandom);
         convert(n[0] ^ n[3], (n == 8) ? 1'b0 : 1'($urandom), n[2:0],
            16'(8 + $urandom % 8), 16'($urandom % 4));
         $display("Test conversion %0d done", n);
      end
      wr(OFF_POSSEL, {24'h0, TEMP_SENSOR_SEL});
      for (k = 0; k < 3 && actPos !== TEMP_SENSOR_SEL; k++) @(posedge clk_sys);
      check(32'(actPos), 32'(TEMP_SENSOR_SEL), "idle");
      check(32'(tempSel), 32'h1, "sensor select");
      curPos = TEMP_SENSOR_SEL;
      nPos = TEMP_SENSOR_SEL;
      nNeg = curNeg;
      convert(1'b0, 1'b0, 3'h0, 16'(TEMP_SAMP_CYC),
         16'(TEMP_INIT_CYC));
      rd(OFF_STATUS, d);
      check({31'h0, d[STAT_TEMPOK_BIT]}, 32'h1, "temp timing");
      $display("Test temperature done");
      conclude();
   end
endmodule : adcf_result_chsel_test
`default_nettype wire
